/* hw/pfs_pkg.sv */
// shared constants, register map and state codes for the flash host
package pfs_pkg;
    localparam int CLK_PERIOD_NS               = 100;
    localparam int ACCESS_NS                   = 100;
    localparam int RESET_PULSE_NS              = 500;
    localparam int READY_IDLE_NS               = 500;
    localparam int READY_ALGO_US               = 20;
    localparam int RESET_HIGH_BEFORE_ACCESS_NS = 50;
    localparam int RESET_TO_STANDBY_TIME_US    = 20;
    localparam int WRITE_CYCLE_MIN_NS          = 100;
    localparam int BUSY_ASSERT_DELAY_NS        = 100;
    localparam int STATUS_POLL_DELAY_US        = 4;

    // least times round up, never below one cycle
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        cyc_up = (c < 1) ? 1 : c;
    endfunction

    localparam int SYNC_LAT      = 4;
    localparam int ACC_CYC       = cyc_up(ACCESS_NS);
    localparam int RD_CYC        = ACC_CYC + SYNC_LAT;
    localparam int GAP_CYC       = 1;
    localparam int PULSE_CYC     = cyc_up(RESET_PULSE_NS);
    localparam int IDLE_RDY_CYC  = cyc_up(READY_IDLE_NS);
    localparam int RST_LOW_CYC   = (PULSE_CYC > IDLE_RDY_CYC) ?
                                   PULSE_CYC : IDLE_RDY_CYC;
    localparam int RST_ALGO_CYC  = cyc_up(READY_ALGO_US * 1000);
    localparam int RH_CYC        = cyc_up(RESET_HIGH_BEFORE_ACCESS_NS);
    localparam int STANDBY_CYC   = cyc_up(RESET_TO_STANDBY_TIME_US * 1000);
    localparam int WC_CYC        = cyc_up(WRITE_CYCLE_MIN_NS);
    localparam int WR_LOW_CYC    = 1;
    localparam int WR_HIGH_CYC   = (WC_CYC > WR_LOW_CYC) ?
                                   WC_CYC - WR_LOW_CYC : 1;
    localparam int BUSY_DLY_CYC  = cyc_up(BUSY_ASSERT_DELAY_NS) + SYNC_LAT;
    localparam int POLL_CYC      = cyc_up(STATUS_POLL_DELAY_US * 1000);
    localparam int TMR_W         = 8;

    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_ADDR     = 8'h04;
    localparam logic [7:0] REG_WDATA    = 8'h08;
    localparam logic [7:0] REG_RDATA    = 8'h0C;
    localparam logic [7:0] REG_STATUS   = 8'h10;
    localparam logic [7:0] REG_INT_STAT = 8'h14;
    localparam logic [7:0] REG_INT_EN   = 8'h18;
    localparam logic [7:0] REG_INT_CLR  = 8'h1C;

    localparam int CTRL_CMD_LSB    = 0;
    localparam int CTRL_FINAL_BIT  = 3;
    localparam int CTRL_SUSP_BIT   = 4;
    localparam int CTRL_RESUME_BIT = 5;

    localparam logic [2:0] CMD_READ    = 3'h1;
    localparam logic [2:0] CMD_WRITE   = 3'h2;
    localparam logic [2:0] CMD_POLL    = 3'h3;
    localparam logic [2:0] CMD_RESET   = 3'h4;
    localparam logic [2:0] CMD_STANDBY = 3'h5;

    localparam int INT_W        = 3;
    localparam int INT_CMD_DONE = 0;
    localparam int INT_ALGO_END = 1;
    localparam int INT_STANDBY  = 2;

    localparam int ST_ACTIVE  = 0;
    localparam int ST_READY   = 1;
    localparam int ST_HOLD    = 2;
    localparam int ST_STANDBY = 3;

    localparam int POLLING_STATUS_BIT = 7;
    localparam int TOGGLE_STATUS_BIT  = 6;

    typedef enum logic [3:0] {
        S_IDLE      = 4'h0,
        S_RD        = 4'h1,
        S_RD_GAP    = 4'h2,
        S_WR_LOW    = 4'h3,
        S_WR_HIGH   = 4'h4,
        S_BUSY_DLY  = 4'h5,
        S_BUSY_WAIT = 4'h6,
        S_POLL_HOLD = 4'h7,
        S_RST_LOW   = 4'h8,
        S_RST_HIGH  = 4'h9,
        S_STANDBY   = 4'hA
    } pfs_state_e;
endpackage

/* hw/pfs_sync.sv */
// three-stage pin synchroniser, output moves when stages two and three agree
`timescale 1ns/1ps
module pfs_sync #(
    parameter int           W    = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] agree;

    assign agree = ~(s2_reg ^ s3_reg);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            dout   <= INIT;
        end
        else
        begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            dout   <= (s3_reg & agree) | (dout & ~agree);
        end
    end
endmodule // pfs_sync

/* hw/pfs_timer.sv */
// loadable down counter; expired while the count sits at zero
`timescale 1ns/1ps
module pfs_timer #(
    parameter int W = 8
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic [W-1:0] loadValue,
    output logic              expired
);
    logic [W-1:0] cnt_reg;

    assign expired = (cnt_reg == '0);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            cnt_reg <= '0;
        else if (load)
            cnt_reg <= loadValue;
        else if (!expired)
            cnt_reg <= cnt_reg - 1'b1;
    end
endmodule // pfs_timer

/* hw/pfs_flash_host.sv */
// host sequencer driving an asynchronous parallel nor flash by its pins
`timescale 1ns/1ps
module pfs_flash_host
    import pfs_pkg::*;
#(
    parameter int AW = 20,
    parameter int DW = 16
) (
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic [7:0]    regAddr,
    input  wire logic [31:0]   regWdata,
    input  wire logic          regWr,
    input  wire logic          regRd,
    output logic      [31:0]   regRdata,
    output logic               irq,
    output logic      [AW-1:0] flashAddr,
    output logic      [DW-1:0] flashDqOut,
    output logic               flashDqOe,
    input  wire logic [DW-1:0] flashDqIn,
    output logic               flashCeN,
    output logic               flashOeN,
    output logic               flashWeN,
    output logic               flashResetN,
    input  wire logic          flashReadyBusyN
);
    pfs_state_e         state_reg;
    pfs_state_e         state_next;
    logic [AW-1:0]      addr_reg;
    logic [DW-1:0]      wdata_reg;
    logic [DW-1:0]      rdata_reg;
    logic               final_reg;
    logic               pollMode_reg;
    logic               pollSecond_reg;
    logic               prevToggle_reg;
    logic               progTiming_reg;
    logic               holdPending_reg;
    logic               holdActive_reg;
    logic               wake_reg;
    logic               stby_reg;
    logic               rbPrev_reg;
    logic [INT_W-1:0]   intStat_reg;
    logic [INT_W-1:0]   intEn_reg;
    logic [INT_W-1:0]   intEvt;
    logic [7:0]         rstLowCnt_reg;
    logic               seqLoad;
    logic [TMR_W-1:0]   seqVal;
    logic               seqExp;
    logic               progLoad;
    logic               progExp;
    logic               stepDone;
    logic               captureRd;
    logic [DW:0]        syncOut;
    logic               rbSync;
    logic [DW-1:0]      dqSync;
    logic [31:0]        readMux;

    function automatic logic [TMR_W-1:0] tv(input int n);
        tv = TMR_W'(n - 1);
    endfunction

    pfs_sync #(
        .W    (DW + 1),
        .INIT ({1'b1, {DW{1'b0}}})
    ) u_sync (
        .clock (clock),
        .rst   (rst),
        .din   ({flashReadyBusyN, flashDqIn}),
        .dout  (syncOut)
    );

    assign rbSync = syncOut[DW];
    assign dqSync = syncOut[DW-1:0];

    pfs_timer #(.W(TMR_W)) u_seq_tmr (
        .clock     (clock),
        .rst       (rst),
        .load      (seqLoad),
        .loadValue (seqVal),
        .expired   (seqExp)
    );

    // one timer serves both the since-program and the after-resume wait
    pfs_timer #(.W(TMR_W)) u_poll_tmr (
        .clock     (clock),
        .rst       (rst),
        .load      (progLoad),
        .loadValue (tv(POLL_CYC)),
        .expired   (progExp)
    );

    // register port decode
    wire        selCtrl   = (regAddr == REG_CTRL);
    wire        selAddr   = (regAddr == REG_ADDR);
    wire        selWdata  = (regAddr == REG_WDATA);
    wire        selRdata  = (regAddr == REG_RDATA);
    wire        selStatus = (regAddr == REG_STATUS);
    wire        selIntSt  = (regAddr == REG_INT_STAT);
    wire        selIntEn  = (regAddr == REG_INT_EN);
    wire        selIntClr = (regAddr == REG_INT_CLR);
    wire [2:0]  cmdCode   = regWdata[CTRL_CMD_LSB +: 3];
    wire        cmdWr     = regWr && selCtrl;
    wire        cmdAccept = cmdWr && (state_reg == S_IDLE);
    wire        isWrite   = cmdAccept && (cmdCode == CMD_WRITE);
    wire        wrFinal   = isWrite && regWdata[CTRL_FINAL_BIT];
    wire        wrSusp    = isWrite && regWdata[CTRL_SUSP_BIT];
    wire        wrResume  = isWrite && regWdata[CTRL_RESUME_BIT];
    wire        holdBlock = holdActive_reg && !progExp;
    wire        toggleSame = (dqSync[TOGGLE_STATUS_BIT] == prevToggle_reg);
    wire        rbRise    = rbSync && !rbPrev_reg;
    wire        stbyEvt   = (state_reg == S_STANDBY) && seqExp && !stby_reg;
    wire [INT_W-1:0] intClr = (regWr && selIntClr) ?
                              regWdata[INT_W-1:0] : '0;
    wire [INT_W-1:0] intStat_next = (intStat_reg & ~intClr) | intEvt;

    assign intEvt[INT_CMD_DONE] = stepDone;
    assign intEvt[INT_ALGO_END] = rbRise;
    assign intEvt[INT_STANDBY]  = stbyEvt;
    assign irq = |(intStat_reg & intEn_reg);

    // pin levels follow the next state so every pin leaves a flip-flop
    wire ceNNext  = !(state_next inside {S_RD, S_WR_LOW, S_WR_HIGH});
    wire oeNNext  = !(state_next == S_RD);
    wire weNNext  = !(state_next == S_WR_LOW);
    wire dqOeNext = (state_next inside {S_WR_LOW, S_WR_HIGH});
    wire rstNNext = !(state_next inside {S_RST_LOW, S_STANDBY});

    assign readMux =
        selCtrl   ? {28'h0, state_reg} :
        selAddr   ? {{(32 - AW){1'b0}}, addr_reg} :
        selWdata  ? {{(32 - DW){1'b0}}, wdata_reg} :
        selRdata  ? {{(32 - DW){1'b0}}, rdata_reg} :
        selStatus ? {28'h0, stby_reg, holdActive_reg, rbSync,
                     state_reg != S_IDLE} :
        selIntSt  ? {{(32 - INT_W){1'b0}}, intStat_reg} :
        selIntEn  ? {{(32 - INT_W){1'b0}}, intEn_reg} :
        32'h0000_0000;

    always_comb
    begin
        state_next = state_reg;
        seqLoad    = 1'b0;
        seqVal     = '0;
        stepDone   = 1'b0;
        captureRd  = 1'b0;
        case (state_reg)
            S_IDLE:
                if (cmdAccept)
                begin
                    seqLoad = 1'b1;
                    case (cmdCode)
                        CMD_READ:
                        begin
                            state_next = S_RD;
                            seqVal     = tv(RD_CYC);
                        end
                        CMD_WRITE:
                        begin
                            state_next = S_WR_LOW;
                            seqVal     = tv(WR_LOW_CYC);
                        end
                        CMD_POLL:
                        begin
                            // early suspend: status not valid yet
                            state_next = holdBlock ? S_POLL_HOLD : S_RD;
                            seqVal     = tv(RD_CYC);
                        end
                        CMD_RESET:
                        begin
                            // busy device needs the long abort window
                            state_next = S_RST_LOW;
                            seqVal     = rbSync ? tv(RST_LOW_CYC)
                                                : tv(RST_ALGO_CYC);
                        end
                        CMD_STANDBY:
                        begin
                            state_next = S_STANDBY;
                            seqVal     = tv(STANDBY_CYC);
                        end
                        default:
                            seqLoad = 1'b0;
                    endcase
                end
            S_RD:
                if (seqExp)
                begin
                    captureRd = 1'b1;
                    // toggle bit is address-independent, so any address polls
                    if (!pollMode_reg ||
                        (pollSecond_reg && toggleSame))
                    begin
                        state_next = S_IDLE;
                        stepDone   = 1'b1;
                    end
                    else
                    begin
                        state_next = S_RD_GAP;
                        seqLoad    = 1'b1;
                        seqVal     = tv(GAP_CYC);
                    end
                end
            S_RD_GAP:
                if (seqExp)
                begin
                    // chip enable cycles high so the next read is a new access
                    state_next = S_RD;
                    seqLoad    = 1'b1;
                    seqVal     = tv(RD_CYC);
                end
            S_WR_LOW:
                if (seqExp)
                begin
                    state_next = S_WR_HIGH;
                    seqLoad    = 1'b1;
                    seqVal     = tv(WR_HIGH_CYC);
                end
            S_WR_HIGH:
                if (seqExp)
                begin
                    seqLoad    = final_reg;
                    seqVal     = tv(BUSY_DLY_CYC);
                    state_next = final_reg ? S_BUSY_DLY : S_IDLE;
                    stepDone   = !final_reg;
                end
            S_BUSY_DLY:
                if (seqExp)
                    state_next = S_BUSY_WAIT;
            S_BUSY_WAIT:
                if (rbSync)
                begin
                    state_next = S_IDLE;
                    stepDone   = 1'b1;
                end
            S_POLL_HOLD:
                if (progExp)
                begin
                    state_next = S_RD;
                    seqLoad    = 1'b1;
                    seqVal     = tv(RD_CYC);
                end
            S_RST_LOW:
                if (seqExp)
                begin
                    state_next = S_RST_HIGH;
                    seqLoad    = 1'b1;
                    seqVal     = tv(RH_CYC);
                end
            S_RST_HIGH:
                if (seqExp)
                begin
                    state_next = S_IDLE;
                    stepDone   = 1'b1;
                end
            S_STANDBY:
                if (seqExp && wake_reg)
                begin
                    state_next = S_RST_HIGH;
                    seqLoad    = 1'b1;
                    seqVal     = tv(RH_CYC);
                end
            default:
                state_next = S_IDLE;
        endcase
    end

    assign progLoad = wrFinal || (wrResume && holdPending_reg);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_reg   <= S_IDLE;
            flashCeN    <= 1'b1;
            flashOeN    <= 1'b1;
            flashWeN    <= 1'b1;
            flashDqOe   <= 1'b0;
            flashResetN <= 1'b1;
        end
        else
        begin
            state_reg   <= state_next;
            flashCeN    <= ceNNext;
            flashOeN    <= oeNNext;
            flashWeN    <= weNNext;
            flashDqOe   <= dqOeNext;
            flashResetN <= rstNNext;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            addr_reg   <= '0;
            wdata_reg  <= '0;
            intEn_reg  <= '0;
            intStat_reg <= '0;
            regRdata   <= 32'h0000_0000;
            rbPrev_reg <= 1'b1;
        end
        else
        begin
            if (regWr && selAddr)
                addr_reg <= regWdata[AW-1:0];
            if (regWr && selWdata)
                wdata_reg <= regWdata[DW-1:0];
            if (regWr && selIntEn)
                intEn_reg <= regWdata[INT_W-1:0];
            intStat_reg <= intStat_next;
            regRdata    <= regRd ? readMux : 32'h0000_0000;
            rbPrev_reg  <= rbSync;
        end
    end

    // pins latch the request so later register writes cannot disturb it
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            flashAddr      <= '0;
            flashDqOut     <= '0;
            final_reg      <= 1'b0;
            pollMode_reg   <= 1'b0;
            pollSecond_reg <= 1'b0;
            prevToggle_reg <= 1'b0;
            rdata_reg      <= '0;
        end
        else
        begin
            if (cmdAccept)
            begin
                flashAddr      <= addr_reg;
                flashDqOut     <= wdata_reg;
                final_reg      <= wrFinal;
                pollMode_reg   <= (cmdCode == CMD_POLL);
                pollSecond_reg <= 1'b0;
            end
            if (captureRd)
            begin
                // polling bit stays in the data as the device reports it
                rdata_reg      <= dqSync;
                prevToggle_reg <= dqSync[TOGGLE_STATUS_BIT];
                pollSecond_reg <= pollMode_reg;
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            progTiming_reg  <= 1'b0;
            holdPending_reg <= 1'b0;
            holdActive_reg  <= 1'b0;
            wake_reg        <= 1'b0;
            stby_reg        <= 1'b0;
        end
        else
        begin
            if (wrFinal)
            begin
                progTiming_reg <= 1'b1;
                holdActive_reg <= 1'b0;
            end
            else if (wrSusp)
            begin
                holdPending_reg <= progTiming_reg && !progExp;
                progTiming_reg  <= 1'b0;
            end
            else if (wrResume && holdPending_reg)
            begin
                holdActive_reg  <= 1'b1;
                holdPending_reg <= 1'b0;
            end
            else if (holdActive_reg && progExp)
                holdActive_reg <= 1'b0;
            if (state_reg != S_STANDBY)
                wake_reg <= 1'b0;
            else if (cmdWr && cmdCode == CMD_RESET)
                wake_reg <= 1'b1;
            stby_reg <= (state_reg == S_STANDBY) && (stby_reg || seqExp);
        end
    end

    // cycles the reset pin has been low, only the checks read it
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rstLowCnt_reg <= 8'h00;
        else if (flashResetN)
            rstLowCnt_reg <= 8'h00;
        else if (rstLowCnt_reg != 8'hFF)
            rstLowCnt_reg <= rstLowCnt_reg + 8'h01;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    AST_RST_PULSE: assert property (
        $rose(flashResetN) |-> (int'(rstLowCnt_reg) >= RST_LOW_CYC))
        else $error("reset pulse shorter than minimum");
    AST_RST_RECOVER: assert property (
        $rose(flashResetN) |-> (flashCeN && flashOeN && flashWeN)
                               ##1 (flashCeN && flashOeN && flashWeN))
        else $error("access started too soon after reset release");
    AST_WR_CYCLE: assert property (
        $fell(flashWeN) |-> (!flashCeN && flashDqOe)
                            ##1 (flashWeN && !flashCeN && flashDqOe)
                            ##1 flashWeN)
        else $error("write cycle too short");
    AST_READY_GO: assert property (
        (state_reg == S_BUSY_WAIT && rbSync)
            |=> (state_reg == S_IDLE) && intStat_reg[INT_CMD_DONE])
        else $error("ready seen but sequence did not finish");
    AST_POLL_HOLD: assert property (
        (state_reg == S_RD && pollMode_reg) |-> !holdBlock)
        else $error("status read inside the poll delay");
    AST_RST_ALGO: assert property (
        ($fell(flashResetN) && !rbSync && state_reg == S_RST_LOW)
            |-> !flashResetN [*8])
        else $error("busy reset released early");
endmodule // pfs_flash_host

/* test/pfs_flash_model.sv */
// behavioural flash device answering the host at its pins
`timescale 1ns/1ps
module pfs_flash_model
    import pfs_pkg::*;
#(
    parameter int LEN = 60
) (
    input  wire logic        clock,
    input  wire logic        ceN,
    input  wire logic        oeN,
    input  wire logic        weN,
    input  wire logic        resetN,
    input  wire logic [15:0] dqOut,
    input  wire logic        algoOn,
    output logic      [15:0] dqIn,
    output logic             readyBusyN,
    output logic             standby
);
    logic [15:0] mem = 16'h0000;
    logic [15:0] target = 16'h0000;
    logic        tog = 1'b0;
    logic        rdOld = 1'b0;
    logic        weOld = 1'b1;
    int          left = 0;
    int          lowCnt = 0;
    wire         rdNow = !ceN && !oeN;
    assign readyBusyN = (left == 0);
    assign standby = (lowCnt >= STANDBY_CYC);
    initial dqIn = 16'h0000;
    // falling edge: data settle half a cycle after the pins move
    always @(negedge clock)
    begin
        rdOld <= rdNow;
        weOld <= weN;
        lowCnt <= resetN ? 0 : lowCnt + 1;
        if (left > 0)
            left <= left - 1;
        if (left == 1)
            mem <= target;
        if (!weOld && weN && !ceN)
        begin
            // an erase clears the word only after zeroing it
            mem <= (algoOn && dqOut == 16'hFFFF) ?
                   16'h0000 : dqOut;
            target <= dqOut;
            if (algoOn)
                left <= LEN;
        end
        if (!resetN)
            left <= 0;
        if (rdNow && !rdOld && left > 0)
        begin
            tog <= !tog;
            // no sector erase-suspended, suspend toggle holds
            dqIn <= {mem[15:8], !target[7], !tog, mem[5:0]};
        end
        else if (rdNow && !rdOld)
            dqIn <= mem;
        else if (!rdNow)
            dqIn <= ~dqIn; // released bus, no pull
    end
endmodule // pfs_flash_model

/* test/test_pfs_flash_host.sv */
// self-checking bench for the flash host sequencer
`timescale 1ns/1ps
module test_pfs_flash_host;
    import pfs_pkg::*;
    logic clock = 0, rst = 1, regWr = 0, regRd = 0, irq, algoOn = 0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, w, d;
    logic [19:0] fAddr;
    logic [15:0] dqO, dqI;
    logic dqOe, ceN, oeN, weN, resN, rbN, devStby;
    int miscompares = 0, checked = 0, cyc = 0, rlow = 0, seed = 10057;
    logic [15:0] expMem;
    always #50 clock = ~clock;
    pfs_flash_host pfs_flash_host_inst (.clock(clock), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .irq(irq), .flashAddr(fAddr),
        .flashDqOut(dqO), .flashDqOe(dqOe), .flashDqIn(dqI),
        .flashCeN(ceN), .flashOeN(oeN), .flashWeN(weN),
        .flashResetN(resN), .flashReadyBusyN(rbN));
    pfs_flash_model pfs_flash_model_inst (.clock(clock), .ceN(ceN),
        .oeN(oeN), .weN(weN), .resetN(resN), .dqOut(dqO),
        .algoOn(algoOn), .dqIn(dqI), .readyBusyN(rbN), .standby(devStby));
    always @(posedge clock)
    begin
        cyc++;
        if (!resN)
            rlow++;
        if (cyc == 20000)
        begin
            miscompares++;
            finish_test;
        end
    end
    task automatic finish_test;
        if (miscompares == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        regWr <= 1;
        regAddr <= a;
        regWdata <= v;
        @(posedge clock);
        regWr <= 0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        regRd <= 1;
        regAddr <= a;
        @(posedge clock);
        regRd <= 0;
        #1 v = regRdata;
    endtask
    // bounded wait on the done flag; standby never sets it
    task automatic run(input logic [31:0] c, input logic ie);
        logic [31:0] s;
        s = 32'h0;
        wr(REG_CTRL, c);
        for (int i = 0; i < 300 && !s[INT_CMD_DONE]; i++)
            rd(REG_INT_STAT, s);
        if (ie)
            chk("irq", 1, irq);
        wr(REG_INT_CLR, 32'h7);
    endtask
    initial
    begin
        repeat (4) @(posedge clock);
        rst <= 0;
        w = $random(seed);
        expMem = w[15:0];
        wr(REG_ADDR, {12'h000, w[31:12]});
        wr(REG_WDATA, {16'h0000, expMem});
        run({29'h0, CMD_WRITE}, 0);
        chk("addr", {12'h000, w[31:12]}, {12'h000, fAddr});
        run({29'h0, CMD_READ}, 0);
        rd(REG_RDATA, d);
        chk("read", {16'h0000, expMem}, d);
        w = $random(seed);
        expMem = w[15:0];
        algoOn <= 1;
        wr(REG_WDATA, {16'h0000, expMem});
        wr(REG_INT_EN, 32'h1);
        run({29'h0, CMD_WRITE} | 32'h8, 1);
        rd(REG_STATUS, d);
        chk("ready", 1, d[ST_READY]);
        // plain write starts the algorithm, so the poll sees it busy
        run({29'h0, CMD_WRITE}, 1);
        run({29'h0, CMD_POLL}, 1);
        rd(REG_RDATA, d);
        chk("poll", {16'h0000, expMem}, d);
        run({29'h0, CMD_WRITE}, 1);
        rlow = 0;
        run({29'h0, CMD_RESET}, 1);
        chk("rstalgo", RST_ALGO_CYC, 32'(rlow));
        algoOn <= 0;
        rlow = 0;
        run({29'h0, CMD_RESET}, 1);
        chk("rstlow", RST_LOW_CYC, 32'(rlow));
        // suspend soon after the final write, then resume: poll must wait
        run({29'h0, CMD_WRITE} | 32'h8, 0);
        run({29'h0, CMD_WRITE} | 32'h10, 0);
        run({29'h0, CMD_WRITE} | 32'h20, 0);
        rd(REG_STATUS, d);
        chk("hold", 1, d[ST_HOLD]);
        run({29'h0, CMD_POLL}, 0);
        rd(REG_STATUS, d);
        chk("holdend", 0, d[ST_HOLD]);
        wr(REG_INT_EN, 32'h0);
        run({29'h0, CMD_STANDBY}, 0);
        rd(REG_STATUS, d);
        chk("standby", 1, d[ST_STANDBY]);
        chk("devstby", 1, devStby);
        run({29'h0, CMD_RESET}, 0);
        rd(8'h20, d);
        chk("unmapped", 0, d);
        chk("irqoff", 0, irq);
        finish_test;
    end
endmodule // test_pfs_flash_host
